// *** src/pfei_map.vh ***
// constants of the format escape interpreter
`ifndef PFEI_MAP_VH
`define PFEI_MAP_VH
// register offsets
`define OFS_CONTROL 3'h0
`define OFS_FORM 3'h1
`define OFS_MARGIN 3'h2
`define OFS_POSITION 3'h3
`define OFS_STATUS 3'h4
// control field positions
`define CTL_NL_LO 0
`define CTL_NL_HI 1
`define CTL_ALT 2
`define CTL_SET_LO 4
`define CTL_SET_HI 6
// reset values
`define RST_FORM_LEN 8'h42
`define RST_LINE 8'h01
`define RST_COL 8'h01
`define RST_CHARSET 3'h0
// limits
`define MAX_LINES 168
`define MAX_PARAMS 16
`define PARAM_SAT 12'h0ff
// character codes
`define CH_ESC 8'h1b
`define CH_BEL 8'h07
`define CH_LF 8'h0a
`define CH_VT 8'h0b
`define CH_FF 8'h0c
`define CH_CR 8'h0d
`define CH_CAN 8'h18
`define CH_SUB 8'h1a
`define CH_SEMI 8'h3b
`define CH_QUEST 8'h3f
// charset codes
`define SET_US 3'h0
`define SET_GB 3'h1
`define SET_FI 3'h2
`define SET_NO 3'h3
`define SET_SE 3'h4
`define SET_DE 3'h5
`define SET_FR 3'h6
`endif

// *** src/charset_glyph_map.v ***
// national character substitution
`timescale 1ns/10ps
`include "pfei_map.vh"
module charset_glyph_map (
  input wire [7:0] i_code,
  input wire [2:0] i_set,
  output reg [7:0] o_glyph
);
  reg [3:0] pos;
  reg hit;
  always @* begin
    hit = 1'b1;
    pos = 4'h0;
    case (i_code)
      8'h23: pos = 4'h0;
      8'h40: pos = 4'h1;
      8'h5b: pos = 4'h2;
      8'h5c: pos = 4'h3;
      8'h5d: pos = 4'h4;
      8'h5e: pos = 4'h5;
      8'h60: pos = 4'h6;
      8'h7b: pos = 4'h7;
      8'h7c: pos = 4'h8;
      8'h7d: pos = 4'h9;
      8'h7e: pos = 4'ha;
      default: hit = 1'b0;
    endcase
    // british differs only at 043
    if (i_set == `SET_US) begin
      hit = 1'b0;
    end else if (i_set == `SET_GB && pos != 4'h0) begin
      hit = 1'b0;
    end
    // national glyph: top bit, set, position
    if (hit) begin
      o_glyph = {1'b1, i_set, pos};
    end else begin
      o_glyph = i_code;
    end
  end
endmodule // charset_glyph_map

// *** src/printer_format_escape_interpreter.v ***
// escape and control interpreter for a serial printing terminal
// Function
// - form length n: margins 1..n, line 1
// - r sets top, bottom; leading semicolon bottom
// - ESC J or ESC 3 set stop here
// - g 1 clears here; g 4, ESC 4 all
// - v sets stops at up to 16 lines
// - attributes request answered with fixed reply
// - ESC = enables, ESC > disables alt keypad
// - british set swaps only code 043
// - national sets differ at eleven positions
// - columns and lines count from one
// - printable advances column, linefeed line
// - active line advances, or returns to top at wrap, FF, VT without stop
// - bell carries only its active line
// - newline mode: LF VT FF reset column
// - setup choice 2 enables, 1/3 disable
// - decimal parameters, missing means zero
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "pfei_map.vh"
module printer_format_escape_interpreter #(
  parameter [7:0] REPLY_CODE = 8'h31 // arbitrary identity digit
) (
  input wire i_clock,
  input wire i_arst_n,
  input wire i_char_valid,
  input wire [7:0] i_char,
  output reg o_print_valid,
  output reg [7:0] o_print_glyph,
  output reg o_bell,
  output reg [7:0] o_bell_line,
  output reg o_reply_valid,
  output reg [7:0] o_reply_char,
  input wire i_reply_ready,
  output wire [7:0] o_active_line,
  output wire [7:0] o_active_column,
  output wire o_alt_keypad,
  output wire o_lf_newline,
  input wire [2:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [15:0] o_reg_rdata
);
  localparam [1:0] ST_GROUND = 2'h0;
  localparam [1:0] ST_ESC = 2'h1;
  localparam [1:0] ST_CSI = 2'h2;
  localparam [1:0] ST_SET = 2'h3;

  reg [1:0] state_reg;
  reg [7:0] line_reg;
  reg [7:0] col_reg;
  reg [7:0] form_reg;
  reg [7:0] top_reg;
  reg [7:0] bot_reg;
  reg [`MAX_LINES-1:0] vstop_reg;
  reg alt_reg;
  reg lfnl_reg;
  reg [2:0] set_reg;
  reg [7:0] par_reg [0:`MAX_PARAMS-1];
  reg [3:0] pidx_reg;
  reg pfull_reg;
  reg bad_reg;
  reg [2:0] rep_reg;
  integer k;

  assign o_active_line = line_reg;
  assign o_active_column = col_reg;
  assign o_alt_keypad = alt_reg;
  assign o_lf_newline = lfnl_reg;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  wire [7:0] glyph;
  charset_glyph_map u_map (
    .i_code(i_char),
    .i_set(set_reg),
    .o_glyph(glyph)
  );

  wire [7:0] p0 = par_reg[0];
  wire [7:0] p1 = par_reg[1];
  wire [7:0] cur_par = par_reg[pidx_reg];
  wire [11:0] acc_full = {4'h0, cur_par} * 12'h00a + {8'h00, i_char[3:0]};
  // saturating decimal accumulation
  wire [7:0] acc_next = (acc_full > `PARAM_SAT) ? 8'hff :
    acc_full[7:0];
  wire is_digit = i_char >= 8'h30 && i_char <= 8'h39;
  wire is_final = i_char >= 8'h40 && i_char <= 8'h7e;
  wire printable = i_char >= 8'h20 && i_char <= 8'h7e;

  // linefeed target: wraps to top at the bottom margin or outside the margins
  reg [7:0] lf_line;
  always @* begin
    if (line_reg < top_reg || line_reg >= bot_reg) begin
      lf_line = top_reg;
    end else begin
      lf_line = line_reg + 8'h01;
    end
  end

  // next vertical stop below the active line
  reg [7:0] vt_line;
  reg vt_found;
  always @* begin
    vt_line = top_reg;
    vt_found = 1'b0;
    for (k = `MAX_LINES; k >= 1; k = k - 1) begin
      if (vstop_reg[k-1] && k > line_reg && k <= bot_reg) begin
        vt_line = k[7:0];
        vt_found = 1'b1;
      end
    end
  end

  // stop mask from the collected parameter list
  reg [`MAX_LINES-1:0] vset_mask;
  always @* begin
    vset_mask = {`MAX_LINES{1'b0}};
    for (k = 0; k < `MAX_PARAMS; k = k + 1) begin
      if (k <= pidx_reg && par_reg[k] >= 8'h01 &&
          par_reg[k] <= `MAX_LINES) begin
        vset_mask[par_reg[k]-8'h01] = 1'b1;
      end
    end
  end

  wire [7:0] new_top = (p0 != 8'h00) ? p0 : top_reg;
  wire [7:0] new_bot = (p1 != 8'h00) ? p1 : bot_reg;
  wire marg_ok = new_top >= 8'h01 && new_top <= new_bot &&
    new_bot <= form_reg;

  ////////////////////////////////////////////////////////////////////////
  // interpreter
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= ST_GROUND;
      line_reg <= `RST_LINE;
      col_reg <= `RST_COL;
      form_reg <= `RST_FORM_LEN;
      top_reg <= `RST_LINE;
      bot_reg <= `RST_FORM_LEN;
      vstop_reg <= {`MAX_LINES{1'b0}};
      alt_reg <= 1'b0;
      lfnl_reg <= 1'b0;
      set_reg <= `RST_CHARSET;
      pidx_reg <= 4'h0;
      pfull_reg <= 1'b0;
      bad_reg <= 1'b0;
      o_print_valid <= 1'b0;
      o_print_glyph <= 8'h00;
      o_bell <= 1'b0;
      o_bell_line <= 8'h00;
      for (k = 0; k < `MAX_PARAMS; k = k + 1) begin
        par_reg[k] <= 8'h00;
      end
    end else begin
      o_print_valid <= 1'b0;
      o_bell <= 1'b0;
      // operator setup through the register port
      if (i_reg_wr && i_reg_addr == `OFS_CONTROL) begin
        if (i_reg_wdata[`CTL_NL_HI:`CTL_NL_LO] == 2'h2) begin
          lfnl_reg <= 1'b1;
        end else if (i_reg_wdata[`CTL_NL_HI:`CTL_NL_LO] != 2'h0) begin
          lfnl_reg <= 1'b0;
        end
        alt_reg <= i_reg_wdata[`CTL_ALT];
        if (i_reg_wdata[`CTL_SET_HI:`CTL_SET_LO] <= `SET_FR) begin
          set_reg <= i_reg_wdata[`CTL_SET_HI:`CTL_SET_LO];
        end
      end
      if (i_char_valid) begin
        if (i_char == `CH_ESC) begin
          state_reg <= ST_ESC;
        end else if (i_char == `CH_CAN || i_char == `CH_SUB) begin
          state_reg <= ST_GROUND;
        end else begin
          case (state_reg)
            ST_GROUND: begin
              if (printable) begin
                o_print_valid <= 1'b1;
                o_print_glyph <= glyph;
                if (col_reg != 8'hff) begin
                  col_reg <= col_reg + 8'h01;
                end
              end else if (i_char == `CH_LF) begin
                line_reg <= lf_line;
                if (lfnl_reg) col_reg <= `RST_COL;
              end else if (i_char == `CH_VT) begin
                line_reg <= vt_line;
                if (lfnl_reg) col_reg <= `RST_COL;
              end else if (i_char == `CH_FF) begin
                line_reg <= top_reg;
                if (lfnl_reg) col_reg <= `RST_COL;
              end else if (i_char == `CH_CR) begin
                col_reg <= `RST_COL;
              end else if (i_char == `CH_BEL) begin
                o_bell <= 1'b1;
                o_bell_line <= line_reg;
              end
            end
            ST_ESC: begin
              state_reg <= ST_GROUND;
              pidx_reg <= 4'h0;
              pfull_reg <= 1'b0;
              bad_reg <= 1'b0;
              for (k = 0; k < `MAX_PARAMS; k = k + 1) begin
                par_reg[k] <= 8'h00;
              end
              case (i_char)
                8'h5b: state_reg <= ST_CSI;
                8'h28: state_reg <= ST_SET;
                8'h4a, 8'h33: vstop_reg[line_reg-8'h01] <= 1'b1;
                8'h34: vstop_reg <= {`MAX_LINES{1'b0}};
                8'h3d: alt_reg <= 1'b1;
                8'h3e: alt_reg <= 1'b0;
                8'h44: line_reg <= lf_line;
                8'h45: begin
                  line_reg <= lf_line;
                  col_reg <= `RST_COL;
                end
                default: state_reg <= ST_GROUND;
              endcase
            end
            ST_SET: begin
              state_reg <= ST_GROUND;
              case (i_char)
                8'h41: set_reg <= `SET_GB;
                8'h42: set_reg <= `SET_US;
                8'h43: set_reg <= `SET_FI;
                8'h45: set_reg <= `SET_NO;
                8'h48: set_reg <= `SET_SE;
                8'h4b: set_reg <= `SET_DE;
                8'h52: set_reg <= `SET_FR;
                default: state_reg <= ST_GROUND;
              endcase
            end
            ST_CSI: begin
              if (is_digit) begin
                if (!pfull_reg) par_reg[pidx_reg] <= acc_next;
              end else if (i_char == `CH_SEMI) begin
                if (pidx_reg == 4'hf) begin
                  pfull_reg <= 1'b1;
                end else begin
                  pidx_reg <= pidx_reg + 4'h1;
                end
              end else if (is_final) begin
                state_reg <= ST_GROUND;
                if (!bad_reg) begin
                  case (i_char)
                    8'h74: begin
                      if (p0 >= 8'h01 && p0 <= `MAX_LINES) begin
                        form_reg <= p0;
                        top_reg <= 8'h01;
                        bot_reg <= p0;
                        line_reg <= 8'h01;
                      end
                    end
                    8'h72: begin
                      if (marg_ok) begin
                        top_reg <= new_top;
                        bot_reg <= new_bot;
                        if (line_reg < new_top) line_reg <= new_top;
                      end
                    end
                    8'h67: begin
                      if (p0 == 8'h01) begin
                        vstop_reg[line_reg-8'h01] <= 1'b0;
                      end else if (p0 == 8'h04) begin
                        vstop_reg <= {`MAX_LINES{1'b0}};
                      end
                    end
                    8'h76: vstop_reg <= vstop_reg | vset_mask;
                    default: state_reg <= ST_GROUND;
                  endcase
                end
              end else if (i_char >= 8'h20) begin
                bad_reg <= 1'b1;
              end
            end
            default: state_reg <= ST_GROUND;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // attribute reply sequencer
  wire da_req = i_char_valid && state_reg == ST_CSI && i_char == 8'h63 &&
    !bad_reg && pidx_reg == 4'h0 && p0 == 8'h00;
  wire [2:0] rep_step = rep_reg + 3'h1;
  reg [7:0] rep_byte;
  always @* begin
    case (rep_step)
      3'h1: rep_byte = `CH_ESC;
      3'h2: rep_byte = 8'h5b;
      3'h3: rep_byte = `CH_QUEST;
      3'h4: rep_byte = REPLY_CODE;
      default: rep_byte = 8'h63;
    endcase
  end
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rep_reg <= 3'h0;
      o_reply_valid <= 1'b0;
      o_reply_char <= 8'h00;
    end else if (rep_reg == 3'h0) begin
      if (da_req) begin
        rep_reg <= 3'h1;
        o_reply_valid <= 1'b1;
        o_reply_char <= `CH_ESC;
      end
    end else if (i_reply_ready) begin
      if (rep_reg == 3'h5) begin
        rep_reg <= 3'h0;
        o_reply_valid <= 1'b0;
      end else begin
        rep_reg <= rep_reg + 3'h1;
        o_reply_char <= rep_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read port
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `OFS_CONTROL: o_reg_rdata <= {9'h000, set_reg, 1'b0, alt_reg,
          1'b0, lfnl_reg};
        `OFS_FORM: o_reg_rdata <= {8'h00, form_reg};
        `OFS_MARGIN: o_reg_rdata <= {bot_reg, top_reg};
        `OFS_POSITION: o_reg_rdata <= {line_reg, col_reg};
        `OFS_STATUS: o_reg_rdata <= {13'h0000, rep_reg != 3'h0,
          state_reg != ST_GROUND, vstop_reg[line_reg-8'h01]};
        default: o_reg_rdata <= 16'h0000;
      endcase
    end else begin
      o_reg_rdata <= 16'h0000;
    end
  end

endmodule // printer_format_escape_interpreter

// *** verif/host_stream_model.sv ***
// host side model: sends the character stream, takes reply bytes
`timescale 1ns/10ps
module host_stream_model (
  input wire i_clock,
  input wire i_reply_valid,
  input wire [7:0] i_reply_char,
  output reg o_char_valid,
  output reg [7:0] o_char,
  output reg o_reply_ready
);
  reg [7:0] replies[$];
  reg [3:0] lfsr;
  initial begin
    o_char_valid = 1'b0;
    o_char = 8'h00;
    o_reply_ready = 1'b0;
    lfsr = 4'h9;
  end
  ////////////////////////////////////////////////////////////////////////
  // ready pattern mixes prompt and slow takes
  always @(posedge i_clock) begin
    lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
    o_reply_ready <= lfsr[0];
    if (i_reply_valid && o_reply_ready) begin
      replies.push_back(i_reply_char);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // decimal digit params only, no space in a sequence
  task send(input [7:0] c);
    begin
      o_char_valid <= 1'b1;
      o_char <= c;
      @(posedge i_clock);
    end
  endtask
  // released line: code flips
  task idle;
    begin
      o_char_valid <= 1'b0;
      o_char <= ~o_char;
      @(posedge i_clock);
    end
  endtask
endmodule // host_stream_model

// *** verif/printer_format_escape_interpreter_checker.sv ***
// port assertions of the format escape interpreter
`timescale 1ns/10ps
module printer_format_escape_interpreter_checker (
  input wire i_clock,
  input wire i_arst_n,
  input wire i_char_valid,
  input wire [7:0] i_char,
  input wire o_print_valid,
  input wire [7:0] o_print_glyph,
  input wire o_bell,
  input wire [7:0] o_bell_line,
  input wire o_reply_valid,
  input wire [7:0] o_reply_char,
  input wire i_reply_ready,
  input wire [7:0] o_active_line,
  input wire [7:0] o_active_column,
  input wire o_alt_keypad,
  input wire o_lf_newline,
  input wire [2:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [15:0] o_reg_rdata
);
  reg last_esc;
  wire [1:0] nl_choice = i_reg_wdata[1:0];
  function nat(input [7:0] c);
    nat = c == 8'h23 || c == 8'h40 || c == 8'h60 ||
      (c >= 8'h5b && c <= 8'h5e) || (c >= 8'h7b && c <= 8'h7e);
  endfunction
  always @(posedge i_clock or negedge i_arst_n)
    if (!i_arst_n) last_esc <= 1'b0;
    else if (i_char_valid) last_esc <= (i_char == 8'h1b);
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  alt_on_a: assert property (
    i_char_valid && i_char == 8'h3d && last_esc |=> o_alt_keypad)
    else $error("alt keypad not enabled");
  pos_nonzero_a: assert property (
    o_active_line != 8'h00 && o_active_column != 8'h00)
    else $error("position at zero");
  print_col_a: assert property (
    o_print_valid && $past(o_active_column) != 8'hff |->
    o_active_column == $past(o_active_column) + 8'h01)
    else $error("column did not advance");
  print_plain_a: assert property (
    o_print_valid && !nat($past(i_char)) |-> o_print_glyph == $past(i_char))
    else $error("plain glyph altered");
  bell_line_a: assert property (
    i_char_valid && i_char == 8'h07 |=>
    o_bell && o_bell_line == $past(o_active_line))
    else $error("bell line wrong");
  lf_column_a: assert property (
    i_char_valid && i_char == 8'h0a && o_lf_newline && !last_esc |=>
    o_active_column == 8'h01)
    else $error("newline column wrong");
  setup_nl_a: assert property (
    i_reg_wr && i_reg_addr == 3'h0 && nl_choice != 2'h0 && !i_char_valid
    |=> o_lf_newline == ($past(nl_choice) == 2'h2))
    else $error("newline setup wrong");
  reply_hold_a: assert property (
    o_reply_valid && !i_reply_ready |=> o_reply_valid && $stable(o_reply_char))
    else $error("reply byte dropped");
  rdata_idle_a: assert property (
    !$past(i_reg_rd) |-> o_reg_rdata == 16'h0000)
    else $error("read data outside slot");
  cover property (o_reply_valid && i_reply_ready);
  cover property (o_bell);
  cover property (o_print_valid && o_print_glyph[7]);
endmodule // printer_format_escape_interpreter_checker
bind printer_format_escape_interpreter
  printer_format_escape_interpreter_checker chk_i (.i_clock, .i_arst_n,
  .i_char_valid, .i_char, .o_print_valid, .o_print_glyph, .o_bell,
  .o_bell_line, .o_reply_valid, .o_reply_char, .i_reply_ready,
  .o_active_line, .o_active_column, .o_alt_keypad, .o_lf_newline,
  .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata);

// *** verif/printer_format_escape_interpreter_tb.sv ***
// self-checking bench of the format escape interpreter
`timescale 1ns/10ps
module printer_format_escape_interpreter_tb;
  localparam [7:0] ID = 8'h37; // arbitrary value
  localparam [39:0] RPLY = {8'h1b, 8'h5b, 8'h3f, ID, 8'h63};
  reg i_clock, i_arst_n, i_reg_wr, i_reg_rd;
  reg [2:0] i_reg_addr;
  reg [15:0] i_reg_wdata;
  wire i_char_valid, o_print_valid, o_bell, o_reply_valid, i_reply_ready;
  wire o_alt_keypad, o_lf_newline;
  wire [7:0] i_char, o_print_glyph, o_bell_line, o_reply_char;
  wire [7:0] o_active_line, o_active_column;
  wire [15:0] o_reg_rdata;
  reg [7:0] glyph, bell_at, c;
  integer n_fail, compares, seed, j, k;
  printer_format_escape_interpreter #(.REPLY_CODE(ID))
    printer_format_escape_interpreter_i (.i_clock, .i_arst_n, .i_char_valid,
    .i_char, .o_print_valid, .o_print_glyph, .o_bell, .o_bell_line,
    .o_reply_valid, .o_reply_char, .i_reply_ready, .o_active_line,
    .o_active_column, .o_alt_keypad, .o_lf_newline, .i_reg_addr,
    .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata);
  host_stream_model host_stream_model_i (.i_clock,
    .i_reply_valid(o_reply_valid), .i_reply_char(o_reply_char),
    .o_char_valid(i_char_valid), .o_char(i_char),
    .o_reply_ready(i_reply_ready));
  always @(posedge i_clock) if (o_print_valid) glyph <= o_print_glyph;
  always @(posedge i_clock) if (o_bell) bell_at <= o_bell_line;
  ////////////////////////////////////////////////////////////////////////
  function nat(input [7:0] x);
    nat = x == 8'h23 || x == 8'h40 || x == 8'h60 ||
      (x >= 8'h5b && x <= 8'h5e) || (x >= 8'h7b && x <= 8'h7e);
  endfunction
  task results;
    begin
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [2:0] a, input [15:0] d);
    begin
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clock);
      i_reg_wr <= 1'b0;
      @(posedge i_clock);
    end
  endtask
  task rc(input [2:0] a, input [15:0] e);
    begin
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_clock);
      i_reg_rd <= 1'b0;
      @(negedge i_clock);
      chk(o_reg_rdata, e);
      @(posedge i_clock);
    end
  endtask
  task say(input [63:0] s);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        if (s[8*i +: 8] != 8'h00) host_stream_model_i.send(s[8*i +: 8]);
      host_stream_model_i.idle;
      repeat (2) @(posedge i_clock);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  initial begin
    seed = 32'h6ec7;
    n_fail = 0;
    compares = 0;
    i_arst_n = 1'b0;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 3'h0;
    i_reg_wdata = 16'h0000;
    repeat (12) @(posedge i_clock);
    i_arst_n <= 1'b1;
    @(posedge i_clock);
    rc(3'h1, 16'h0042);
    rc(3'h2, 16'h4201);
    rc(3'h3, 16'h0101);
    wr(3'h6, 16'hffff);
    rc(3'h7, 16'h0000);
    rc(3'h1, 16'h0042);
    say("AB\n");
    rc(3'h3, 16'h0203);
    say("\015\033[060t");
    rc(3'h1, 16'h003c);
    rc(3'h2, 16'h3c01);
    rc(3'h3, 16'h0101);
    say("\033[3;10r");
    rc(3'h2, 16'h0a03);
    say("\033[;20r");
    rc(3'h2, 16'h1403);
    rc(3'h3, 16'h0301);
    say("\033J");
    rc(3'h4, 16'h0001);
    say("\033[1g");
    rc(3'h4, 16'h0000);
    say("\0333");
    rc(3'h4, 16'h0001);
    say("\0334");
    rc(3'h4, 16'h0000);
    say("\033[5;7v");
    say("\n\n");
    rc(3'h4, 16'h0001);
    say("\n\n");
    say("\033[4g");
    rc(3'h4, 16'h0000);
    host_stream_model_i.send(8'h1b);
    host_stream_model_i.send(8'h5b);
    for (j = 5; j <= 20; j = j + 1) begin
      host_stream_model_i.send(8'(8'h30 + j / 10));
      host_stream_model_i.send(8'(8'h30 + j % 10));
      host_stream_model_i.send(j == 20 ? 8'h76 : 8'h3b);
    end
    say("");
    rc(3'h4, 16'h0001);
    for (j = 8; j <= 20; j = j + 1) begin
      say("\n");
      rc(3'h3, {j[7:0], 8'h01});
      rc(3'h4, 16'h0001);
    end
    wr(3'h0, 16'h0002);
    say("AB\n");
    rc(3'h3, 16'h0301);
    for (j = 1; j <= 3; j = j + 1) begin
      wr(3'h0, j[15:0]);
      rc(3'h0, {15'h0, j == 2});
    end
    say("\033=");
    chk({15'h0, o_alt_keypad}, 16'h0001);
    say("\033>");
    rc(3'h0, 16'h0000);
    say("\007");
    chk({8'h00, bell_at}, 16'h0003);
    for (j = 0; j < 2; j = j + 1) begin
      say(j ? "\033[0c" : "\033[c");
      k = 0;
      while (host_stream_model_i.replies.size() < 5 && k < 60) begin
        @(posedge i_clock);
        k = k + 1;
      end
      if (host_stream_model_i.replies.size() < 5) begin
        n_fail = n_fail + 1;
        results;
      end
      for (k = 0; k < 5; k = k + 1)
        chk({8'h00, host_stream_model_i.replies.pop_front()},
          {8'h00, RPLY[39-8*k -: 8]});
    end
    say("\033[5q");
    rc(3'h1, 16'h003c);
    rc(3'h2, 16'h1403);
    say("\033[?5t");
    rc(3'h1, 16'h003c);
    for (j = 0; j < 7; j = j + 1) begin
      wr(3'h0, {9'h000, j[2:0], 4'h0});
      rc(3'h0, {9'h000, j[2:0], 4'h0});
      c = {1'b1, j[2:0], 4'h0};
      say("#");
      chk({8'h00, glyph}, {8'h00, j ? c : 8'h23});
      c = {1'b1, j[2:0], 4'ha};
      say("~");
      chk({8'h00, glyph}, {8'h00, j > 1 ? c : 8'h7e});
      if (j < 2) begin
        say("@");
        chk({8'h00, glyph}, 16'h0040);
      end
      for (k = 0; k < 4; k = k + 1) begin
        c = 8'(8'h21 + $unsigned($random(seed)) % 94);
        if (nat(c)) c = 8'h41;
        say({56'h0, c});
        chk({8'h00, glyph}, {8'h00, c});
      end
    end
    // mid-run reset restores the format state
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_arst_n <= 1'b1;
    @(posedge i_clock);
    rc(3'h1, 16'h0042);
    rc(3'h3, 16'h0101);
    rc(3'h0, 16'h0000);
    results;
  end
endmodule // printer_format_escape_interpreter_tb
